// file: src/erxf_pkg.sv
package erxf_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int DATA_AW = 9;   // data fifo: 512 dwords
  localparam int STAT_AW = 5;   // status fifo: 32 words

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_DATA_PORT = 8'h00;  // read pops data fifo
  localparam logic [7:0] REG_STAT_PORT = 8'h04;  // read pops status fifo
  localparam logic [7:0] REG_RX_CFG    = 8'h08;  // offset, padding, flush-all
  localparam logic [7:0] REG_DP_CTRL   = 8'h0C;  // receive_datapath_control
  localparam logic [7:0] REG_FILL_INFO = 8'h10;  // rx_fifo_fill_info
  localparam logic [7:0] REG_MAC_CTRL  = 8'h14;  // mac_control
  localparam logic [7:0] REG_EVENTS    = 8'h18;  // sticky events, write one to clear

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CFG_OFF_LSB   = 0;   // 5-bit start offset in bytes
  localparam int CFG_PAD_LSB   = 8;   // 2-bit pad select: 0 off, 1/2/3 = 4/8/16 dwords
  localparam int CFG_DUMP_BIT  = 15;  // flush-all
  localparam int DP_SKIP_BIT   = 31;  // skip_packet_bit
  localparam int CTL_RECEIVER_ENABLE_BIT_BIT  = 0;   // receiver_enable_bit
  localparam int CTL_CSUM_BIT  = 1;   // receive_checksum_enable
  localparam int EVT_ERR_BIT   = 0;   // receiver_error_flag
  localparam int EVT_HALT_BIT  = 1;   // receiver_halted_event
  localparam int INF_STAT_LSB  = 16;  // status words queued
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // status word layout
  // ---------------------------------------------------------------
  localparam int ST_FILT_BIT   = 30;
  localparam int ST_LEN_LSB    = 16;
  localparam int ST_ES_BIT     = 15;
  localparam int ST_RUNT_BIT   = 11;
  localparam int ST_LONG_BIT   = 7;
  localparam int ST_COLL_BIT   = 6;
  localparam int ST_CRC_BIT    = 1;
  localparam logic [13:0] ST_PASS_MASK = 14'h3C7E;  // bits 13..10, 6..1 from the mac
  localparam logic [13:0] MAX_FRAME_LEN = 14'h05EE; // 1518 bytes

  // ---------------------------------------------------------------
  // frame writer states
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    W_IDLE = 7'h01,
    W_LEAD = 7'h02,
    W_DATA = 7'h04,
    W_CSUM = 7'h08,
    W_TAIL = 7'h10,
    W_PAD  = 7'h20,
    W_STAT = 7'h40
  } erxf_wst_e;

endpackage

// file: src/erxf_sfifo.sv
`timescale 1ns/1ps
`default_nettype none
module erxf_sfifo #(
  parameter int W  = 32,
  parameter int AW = 5
) (
  input  wire logic          clk_in,    // system clock
  input  wire logic          rst_in,    // sync reset, active high
  input  wire logic          flush_in,  // pointers back to reset
  input  wire logic          push_in,   // store din
  input  wire logic [W-1:0]  din_in,    // write word
  input  wire logic          pop_in,    // drop head
  output logic      [W-1:0]  dout_out,  // head word
  output logic      [AW:0]   cnt_out,   // words held
  output logic               full_out,  // no room
  output logic               empty_out  // nothing held
);
  logic [W-1:0] mem [2**AW];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  logic [AW:0]  nxt_wp;
  logic [AW:0]  nxt_rp;

  assign cnt_out   = wp_ff - rp_ff;
  assign full_out  = cnt_out[AW];
  assign empty_out = (wp_ff == rp_ff);
  assign dout_out  = mem[rp_ff[AW-1:0]];

  always_comb begin
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    if (flush_in) begin
      nxt_wp = '0;
      nxt_rp = '0;
    end else begin
      if (push_in && !full_out) begin
        nxt_wp = wp_ff + 1'b1;
      end
      if (pop_in && !empty_out) begin
        nxt_rp = rp_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push_in && !full_out && !flush_in) begin
      mem[wp_ff[AW-1:0]] <= din_in;
    end
  end
endmodule
`default_nettype wire

// file: src/erxf_top.sv
// Contract
// - Received frame dwords go into the data fifo, write pointer advancing per word.
// - After each frame's data one status word goes to a separate status fifo.
// - Host may read any available status words before reading frame data.
// - Read underrun of either fifo sets the receiver error flag; host soft-resets.
// - Each frame's data starts after a programmed 0 to 31 byte offset.
// - Optional end padding makes each frame a whole multiple of the burst.
// - Offset and padding apply to each frame separately, boundaries kept.
// - Skip bit discards the head frame, read pointer jumps to next frame.
// - Skip touches only the data fifo, status fifo untouched, receiver running.
// - Flush-all returns both fifos' pointers to reset values.
// - Flush-all bit clears itself once the flush is done.
// - With checksum enabled a four-byte checksum follows the payload.
// - Status bit 31 zero, bit 30 filter fail, bits 29:16 length.
// - Status bit 15 is the OR of bits 11, 7, 6 and 1.
// - Status bit 14 zero, 13 broadcast, 12 length mismatch.
// - Status bit 10 multicast, bit 7 set above 1518 bytes, no truncation.
// - A receiver halt after enable clears pulses the halted event.
// - Status fifo overrun sets the error flag; reception continues.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module erxf_top
  import erxf_pkg::*;
#(
  parameter int DAW = DATA_AW,
  parameter int SAW = STAT_AW
) (
  input  wire logic        clk_in,            // 200 MHz clock
  input  wire logic        rst_in,            // sync reset, active high
  input  wire logic        psel_in,           // apb select
  input  wire logic        penable_in,        // apb access phase
  input  wire logic        pwrite_in,         // apb write
  input  wire logic [7:0]  paddr_in,          // apb byte address
  input  wire logic [31:0] pwdata_in,         // apb write data
  output logic             pready_out,        // apb ready
  output logic      [31:0] prdata_out,        // apb read data
  output logic             pslverr_out,       // apb error, unmapped address
  input  wire logic        mil_valid_in,      // mac_interface_layer dword valid
  input  wire logic [31:0] mil_data_in,       // frame dword, first byte in low lane
  input  wire logic        mil_last_in,       // last dword of frame
  input  wire logic [13:0] mil_len_in,        // frame length, with last
  input  wire logic [13:0] mil_flags_in,      // status bits 13..0, with last
  input  wire logic        mil_filt_fail_in,  // address filter failed, with last
  input  wire logic [31:0] mil_csum_in,       // checksum, with last
  output logic             mil_ready_out,     // dword taken when valid and ready
  output logic             rx_en_out,         // receiver_enable_bit to the mac
  output logic             rx_error_out,      // receiver_error_flag, sticky
  output logic             rx_halted_out      // receiver_halted_event pulse
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  localparam logic [DAW:0] ROOM_MAX = (DAW+1)'(2**DAW - 3);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [31:0]  dmem [2**DAW];
  logic [DAW:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr, used;
  erxf_wst_e    st_ff, nxt_st;
  logic [31:0]  prev_ff, nxt_prev, csum_ff, nxt_csum, stat_ff, nxt_stat, dwdata;
  logic [4:0]   off_ff, nxt_off;
  logic [2:0]   lead_ff, nxt_lead;
  logic [3:0]   wcnt_ff, nxt_wcnt, pad_mask;
  logic         dwr, stat_push, bnd_push, take;
  logic [31:0]  cfg_ff, nxt_cfg, ctl_ff, nxt_ctl;
  logic         skip_ff, nxt_skip, err_ff, nxt_err, hev_ff, nxt_hev;
  logic         run_ff, nxt_run, hpulse_ff, nxt_hpulse, rdy_ff, nxt_rdy;
  logic         pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [31:0]  prdata_ff, nxt_prdata;
  logic         rd_acc, wr_acc, dump, bnd_pop, skip_jump, dpop, spop;
  logic [31:0]  sf_dout;
  logic [SAW:0] sf_cnt, bf_cnt;
  logic         sf_full, sf_empty, bf_full, bf_empty;
  logic [DAW:0] bnd_head;

  assign used      = wr_ptr_ff - rd_ptr_ff;
  assign dump      = cfg_ff[CFG_DUMP_BIT];
  assign rd_acc    = psel_in && penable_in && pready_ff && !pwrite_in;
  assign wr_acc    = psel_in && penable_in && pready_ff && pwrite_in;
  assign dpop      = rd_acc && (paddr_in == REG_DATA_PORT) && (used != '0);
  assign spop      = rd_acc && (paddr_in == REG_STAT_PORT) && !sf_empty;
  assign take      = mil_valid_in && rdy_ff;
  assign bnd_pop   = !bf_empty && (rd_ptr_ff == bnd_head) && !dump;
  assign skip_jump = skip_ff && !bf_empty && (rd_ptr_ff != bnd_head) && !dump;

  function automatic logic [31:0] align(input logic [31:0] cur, input logic [31:0] prv, input logic [1:0] b);
    logic [63:0] t;
    logic [5:0]  sh;
    sh = {3'(3'd4 - {1'b0, b}), 3'b000};
    t  = {cur, prv} >> sh;
    return t[31:0];
  endfunction

  // ---------------------------------------------------------------
  // frame writer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st    = st_ff;
    nxt_prev  = prev_ff;
    nxt_csum  = csum_ff;
    nxt_stat  = stat_ff;
    nxt_off   = off_ff;
    nxt_lead  = lead_ff;
    nxt_wcnt  = wcnt_ff;
    dwr       = 1'b0;
    dwdata    = '0;
    stat_push = 1'b0;
    bnd_push  = 1'b0;
    case (cfg_ff[CFG_PAD_LSB +: 2])
      2'h1:    pad_mask = 4'h3;
      2'h2:    pad_mask = 4'h7;
      default: pad_mask = 4'hF;
    endcase
    case (st_ff)
      W_IDLE: begin
        nxt_off  = cfg_ff[CFG_OFF_LSB +: 5];                    // latched per frame
        nxt_lead = '0;
        nxt_wcnt = '0;
        nxt_prev = '0;
        if (mil_valid_in && ctl_ff[CTL_RECEIVER_ENABLE_BIT_BIT]) begin
          nxt_st = W_LEAD;
        end
      end
      W_LEAD: begin
        if (lead_ff == off_ff[4:2]) begin
          nxt_st = W_DATA;
        end else if (used <= ROOM_MAX) begin
          dwr      = 1'b1;                                      // whole dwords of offset
          nxt_lead = lead_ff + 1'b1;
        end
      end
      W_DATA: begin
        if (take) begin
          dwr      = 1'b1;
          dwdata   = align(mil_data_in, prev_ff, off_ff[1:0]);  // byte part of offset
          nxt_prev = mil_data_in;
          if (mil_last_in) begin
            nxt_csum = mil_csum_in;
            nxt_stat = '0;                                      // 31 and 14 zero
            nxt_stat[ST_FILT_BIT] = mil_filt_fail_in;
            nxt_stat[ST_LEN_LSB +: 14] = mil_len_in;
            nxt_stat[13:0] = mil_flags_in & ST_PASS_MASK;       // 13,12,10 pass
            nxt_stat[ST_LONG_BIT] = (mil_len_in > MAX_FRAME_LEN); // flag only
            nxt_st = ctl_ff[CTL_CSUM_BIT] ? W_CSUM : W_TAIL;
          end
        end
      end
      W_CSUM: begin
        if (used <= ROOM_MAX) begin
          dwr      = 1'b1;                                      // four more bytes
          dwdata   = align(csum_ff, prev_ff, off_ff[1:0]);
          nxt_prev = csum_ff;
          nxt_st   = W_TAIL;
        end
      end
      W_TAIL: begin
        if (off_ff[1:0] == 2'h0) begin
          nxt_st = W_PAD;
        end else if (used <= ROOM_MAX) begin
          dwr    = 1'b1;                                        // spilled bytes of last dword
          dwdata = align('0, prev_ff, off_ff[1:0]);
          nxt_st = W_PAD;
        end
      end
      W_PAD: begin
        if ((cfg_ff[CFG_PAD_LSB +: 2] == 2'h0) || ((wcnt_ff & pad_mask) == 4'h0)) begin
          nxt_st = W_STAT;
        end else if (used <= ROOM_MAX) begin
          dwr = 1'b1;
        end
      end
      W_STAT: begin
        // waiting on a boundary slot keeps skip honest; status overrun does not stall
        if (!bf_full) begin
          nxt_stat[ST_ES_BIT] = stat_ff[ST_RUNT_BIT] | stat_ff[ST_LONG_BIT]
                              | stat_ff[ST_COLL_BIT] | stat_ff[ST_CRC_BIT];
          stat_push = 1'b1;
          bnd_push  = 1'b1;
          nxt_st    = W_IDLE;
        end
      end
      default: nxt_st = W_IDLE;
    endcase
    if (dwr) begin
      nxt_wcnt = wcnt_ff + 1'b1;
    end
    if (dump) begin
      nxt_st = W_IDLE;
    end
    nxt_rdy = (nxt_st == W_DATA) && (used <= ROOM_MAX) && !(take && mil_last_in);
  end

  // ---------------------------------------------------------------
  // pointers, control and events
  // ---------------------------------------------------------------
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_cfg    = cfg_ff;
    nxt_ctl    = ctl_ff;
    nxt_skip   = skip_ff;
    nxt_err    = err_ff;
    nxt_hev    = hev_ff;
    if (dwr) begin
      nxt_wr_ptr = wr_ptr_ff + 1'b1;
    end
    if (skip_jump) begin
      nxt_rd_ptr = bnd_head;
      nxt_skip   = 1'b0;
    end else if (dpop) begin
      nxt_rd_ptr = rd_ptr_ff + 1'b1;
    end
    if (wr_acc) begin
      case (paddr_in)
        REG_RX_CFG:   nxt_cfg = pwdata_in & 32'h0000_831F;
        REG_DP_CTRL:  nxt_skip = pwdata_in[DP_SKIP_BIT] | skip_ff;
        REG_MAC_CTRL: nxt_ctl = pwdata_in & 32'h0000_0003;
        REG_EVENTS: begin
          nxt_err = err_ff & ~pwdata_in[EVT_ERR_BIT];
          nxt_hev = hev_ff & ~pwdata_in[EVT_HALT_BIT];
        end
        default: ;
      endcase
    end
    if (rd_acc && (((paddr_in == REG_DATA_PORT) && (used == '0)) ||
                   ((paddr_in == REG_STAT_PORT) && sf_empty))) begin
      nxt_err = 1'b1;                                           // set wins over clear
    end
    if (stat_push && sf_full) begin
      nxt_err = 1'b1;
    end
    nxt_run    = ctl_ff[CTL_RECEIVER_ENABLE_BIT_BIT] || (st_ff != W_IDLE);
    nxt_hpulse = run_ff && !nxt_run;
    if (nxt_hpulse) begin
      nxt_hev = 1'b1;
    end
    if (dump) begin
      nxt_wr_ptr = '0;
      nxt_rd_ptr = '0;
      nxt_skip   = 1'b0;
      nxt_cfg[CFG_DUMP_BIT] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait-free access phase
  // ---------------------------------------------------------------
  always_comb begin
    nxt_pready  = psel_in && !penable_in;
    nxt_pslverr = 1'b0;
    nxt_prdata  = '0;
    if (psel_in && !penable_in && !pwrite_in) begin
      case (paddr_in)
        REG_DATA_PORT: nxt_prdata = (used != '0) ? dmem[rd_ptr_ff[DAW-1:0]] : '0;
        REG_STAT_PORT: nxt_prdata = sf_empty ? '0 : sf_dout;
        REG_RX_CFG:    nxt_prdata = cfg_ff;
        REG_DP_CTRL:   nxt_prdata = {skip_ff, 31'h0};
        REG_FILL_INFO: nxt_prdata = (32'(sf_cnt) << INF_STAT_LSB) | 32'(used);
        REG_MAC_CTRL:  nxt_prdata = ctl_ff;
        REG_EVENTS:    nxt_prdata = {30'h0, hev_ff, err_ff};
        default:       nxt_pslverr = 1'b1;
      endcase
    end else if (psel_in && !penable_in) begin
      nxt_pslverr = !(paddr_in inside {REG_DATA_PORT, REG_STAT_PORT, REG_RX_CFG,
                                      REG_DP_CTRL, REG_FILL_INFO, REG_MAC_CTRL, REG_EVENTS});
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_ff      <= W_IDLE;
      prev_ff    <= '0;
      csum_ff    <= '0;
      stat_ff    <= '0;
      off_ff     <= '0;
      lead_ff    <= '0;
      wcnt_ff    <= '0;
      wr_ptr_ff  <= '0;
      rd_ptr_ff  <= '0;
      cfg_ff     <= CFG_RESET;
      ctl_ff     <= CTL_RESET;
      skip_ff    <= 1'b0;
      err_ff     <= 1'b0;
      hev_ff     <= 1'b0;
      run_ff     <= 1'b0;
      hpulse_ff  <= 1'b0;
      rdy_ff     <= 1'b0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      st_ff      <= nxt_st;
      prev_ff    <= nxt_prev;
      csum_ff    <= nxt_csum;
      stat_ff    <= nxt_stat;
      off_ff     <= nxt_off;
      lead_ff    <= nxt_lead;
      wcnt_ff    <= nxt_wcnt;
      wr_ptr_ff  <= nxt_wr_ptr;
      rd_ptr_ff  <= nxt_rd_ptr;
      cfg_ff     <= nxt_cfg;
      ctl_ff     <= nxt_ctl;
      skip_ff    <= nxt_skip;
      err_ff     <= nxt_err;
      hev_ff     <= nxt_hev;
      run_ff     <= nxt_run;
      hpulse_ff  <= nxt_hpulse;
      rdy_ff     <= nxt_rdy;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (dwr && !dump) begin
      dmem[wr_ptr_ff[DAW-1:0]] <= dwdata;
    end
  end

  // ---------------------------------------------------------------
  // status fifo and frame boundary list
  // ---------------------------------------------------------------
  erxf_sfifo #(.W(32), .AW(SAW)) u_stat (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .flush_in  (dump),
    .push_in   (stat_push),
    .din_in    (nxt_stat),
    .pop_in    (spop),
    .dout_out  (sf_dout),
    .cnt_out   (sf_cnt),
    .full_out  (sf_full),
    .empty_out (sf_empty)
  );

  erxf_sfifo #(.W(DAW+1), .AW(SAW)) u_bnd (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .flush_in  (dump),
    .push_in   (bnd_push),
    .din_in    (wr_ptr_ff),
    .pop_in    (bnd_pop),
    .dout_out  (bnd_head),
    .cnt_out   (bf_cnt),
    .full_out  (bf_full),
    .empty_out (bf_empty)
  );

  assign pready_out    = pready_ff;
  assign prdata_out    = prdata_ff;
  assign pslverr_out   = pslverr_ff;
  assign mil_ready_out = rdy_ff;
  assign rx_en_out     = ctl_ff[CTL_RECEIVER_ENABLE_BIT_BIT];
  assign rx_error_out  = err_ff;
  assign rx_halted_out = hpulse_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_last_beat;
    mil_valid_in && mil_ready_out && mil_last_in;
  endsequence
  sequence s_close;
    !mil_ready_out ##[1:40] (stat_push || dump);
  endsequence

  // summary and reserved bits judged on the stored word, independent of the writer's own expression
  property p_es;      spop |-> sf_dout[15] == |{sf_dout[11], sf_dout[7], sf_dout[6], sf_dout[1]}; endproperty
  property p_rsvd;    spop |-> !sf_dout[31] && !sf_dout[14]; endproperty
  property p_long;    s_last_beat |=> stat_ff[7] == ($past(mil_len_in) > 14'h05EE); endproperty
  property p_under;   rd_acc && paddr_in == REG_DATA_PORT && used == '0 |=> rx_error_out; endproperty
  property p_dump;    dump |=> wr_ptr_ff == '0 && rd_ptr_ff == '0 && !dump && sf_empty; endproperty
  property p_hold;    skip_ff && bf_empty && !dump |=> skip_ff; endproperty
  property p_jump;    skip_jump |=> rd_ptr_ff == $past(bnd_head) && !skip_ff; endproperty
  property p_ovr;     stat_push && sf_full && !spop && !dump |=> rx_error_out && $stable(sf_cnt); endproperty
  property p_wrp;     dwr && !dump |=> wr_ptr_ff == $past(wr_ptr_ff) + 1'b1; endproperty
  property p_halt;    run_ff && !ctl_ff[0] && st_ff == W_IDLE |=> rx_halted_out ##1 !rx_halted_out; endproperty
  property p_frame;   s_last_beat |=> s_close; endproperty

  a_es:    assert property (p_es)    else $error("error summary bit wrong");
  a_rsvd:  assert property (p_rsvd)  else $error("reserved status bit set");
  a_long:  assert property (p_long)  else $error("too long bit wrong");
  a_under: assert property (p_under) else $error("underrun not flagged");
  a_dump:  assert property (p_dump)  else $error("flush-all incomplete");
  a_hold:  assert property (p_hold)  else $error("skip bit dropped early");
  a_jump:  assert property (p_jump)  else $error("skip did not reach next frame");
  a_ovr:   assert property (p_ovr)   else $error("status overrun not flagged");
  a_wrp:   assert property (p_wrp)   else $error("write pointer not advanced");
  a_halt:  assert property (p_halt)  else $error("halted event not one pulse");
  a_frame: assert property (p_frame) else $error("frame not closed with status");
endmodule
`default_nettype wire

// file: tb/erxf_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module erxf_mac_model (
  input  wire logic        clk_in,     // clock
  input  wire logic        rst_in,     // sync reset
  input  wire logic        go_in,      // start one frame
  input  wire logic [3:0]  n_in,       // dwords in frame
  input  wire logic        ready_in,   // block takes dword
  output logic             valid_out,  // dword valid
  output logic      [31:0] data_out,   // dword
  output logic             last_out    // final dword
);
  logic [3:0] i_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      i_ff      <= 4'h1;
    end else if (go_in && !valid_out) begin
      valid_out <= 1'b1;
      i_ff      <= 4'h1;
    end else if (valid_out && ready_in) begin
      valid_out <= !last_out;
      i_ff      <= i_ff + 4'h1;
    end
  end
  // idle lines show the inverse so a stray sample is caught
  assign data_out = valid_out ? {28'h0, i_ff} : ~{28'h0, i_ff};
  assign last_out = valid_out && (i_ff == n_in);
endmodule
`default_nettype wire

// file: tb/test_erxf_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_erxf_top;
  import erxf_pkg::*;
  logic        clk_in, rst_in, psel, pen, pwr, pready, pslverr, err, go;
  logic        mv, mr, ml, rx_en, rx_err, halted;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, md;
  int          failures, comparisons, cyc, halts;
  // frame b: offset 5, payload, checksum spread over two dwords, then padded to 8 dwords
  localparam logic [31:0] EXP_B [8] = '{32'h0, 32'h0000_0100, 32'h0000_0200, 32'h0000_0300,
                                        32'hC50A_0A00, 32'h0000_00C5, 32'h0, 32'h0};
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  erxf_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .mil_valid_in(mv), .mil_data_in(md), .mil_last_in(ml), .mil_len_in(14'h000C), .mil_flags_in(14'h0002),
    .mil_filt_fail_in(1'b1), .mil_csum_in(32'hC5C5_0A0A), .mil_ready_out(mr), .rx_en_out(rx_en),
    .rx_error_out(rx_err), .rx_halted_out(halted));
  erxf_mac_model i_mac (.clk_in(clk_in), .rst_in(rst_in), .go_in(go), .n_in(4'h3), .ready_in(mr),
    .valid_out(mv), .data_out(md), .last_out(ml));
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (halted === 1'b1) begin
      halts <= halts + 1;
    end
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk_in) pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // one idle edge, so a following call never re-drives psel in the same step
    @(posedge clk_in);
  endtask
  task automatic frame();
    go <= 1'b1;
    @(posedge clk_in) go <= 1'b0;
    rd = 32'h0;
    for (int t = 0; t < 30 && rd[INF_STAT_LSB +: 8] == 8'h0; t++) apb(1'b0, REG_FILL_INFO, 32'h0);
    chk("status queued", {24'h0, rd[INF_STAT_LSB +: 8]}, 32'h1);
  endtask
  task automatic t_frame();
    apb(1'b1, REG_MAC_CTRL, 32'h1);
    chk("enable pin", {31'h0, rx_en}, 32'h1);
    frame();
    apb(1'b0, REG_STAT_PORT, 32'h0);
    chk("status word", rd, 32'h400C_8002);
    for (int k = 1; k <= 3; k++) begin
      apb(1'b0, REG_DATA_PORT, 32'h0);
      chk("data", rd, 32'(k));
    end
    // deliberate status underrun: reads back zero and sets the error flag
    apb(1'b0, REG_STAT_PORT, 32'h0);
    chk("underrun data", rd, 32'h0);
    $display("t_frame done");
  endtask
  task automatic t_flush();
    frame();
    apb(1'b1, REG_MAC_CTRL, 32'h0);
    repeat (4) @(posedge clk_in);
    apb(1'b0, REG_EVENTS, 32'h0);
    chk("events", rd, 32'h3);
    chk("error pin", {31'h0, rx_err}, 32'h1);
    chk("enable pin", {31'h0, rx_en}, 32'h0);
    chk("halt pulses", 32'(halts), 32'h1);
    // flush only once the halted event has been seen
    apb(1'b1, REG_RX_CFG, 32'h0000_8000);
    apb(1'b0, REG_FILL_INFO, 32'h0);
    chk("fill after flush", rd, 32'h0);
    apb(1'b0, REG_RX_CFG, 32'h0);
    chk("flush bit", rd, 32'h0);
    // soft reset after the underrun, as the host must
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    apb(1'b0, REG_EVENTS, 32'h0);
    chk("events after reset", rd, 32'h0);
    $display("t_flush done");
  endtask
  task automatic t_skip();
    int n;
    apb(1'b1, REG_MAC_CTRL, 32'h1);
    apb(1'b1, REG_RX_CFG, 32'h0000_0005);
    frame();
    // one lead dword, three shifted dwords, one spill dword
    chk("fill frame a", rd, 32'h0001_0005);
    apb(1'b0, REG_STAT_PORT, 32'h0);
    chk("status a", rd, 32'h400C_8002);
    apb(1'b1, REG_RX_CFG, 32'h0000_0105);
    apb(1'b1, REG_MAC_CTRL, 32'h3);
    frame();
    chk("fill frame b", rd, 32'h0001_000D);
    // frame a holds five dwords, so skipping it is allowed
    apb(1'b1, REG_DP_CTRL, 32'h8000_0000);
    rd = 32'h8000_0000;
    for (int t = 0; t < 10 && rd[DP_SKIP_BIT]; t++) apb(1'b0, REG_DP_CTRL, 32'h0);
    chk("skip bit", rd, 32'h0);
    apb(1'b0, REG_FILL_INFO, 32'h0);
    chk("fill after skip", rd, 32'h0001_0008);
    apb(1'b0, REG_STAT_PORT, 32'h0);
    chk("status b", rd, 32'h400C_8002);
    n = (((5 + 4 + int'(rd[29:16]) + 3) >> 2) + 3) & ~3;
    for (int k = 0; k < n; k++) begin
      apb(1'b0, REG_DATA_PORT, 32'h0);
      chk("frame b data", rd, EXP_B[k]);
    end
    apb(1'b0, REG_FILL_INFO, 32'h0);
    chk("fill at end", rd, 32'h0);
    $display("t_skip done");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    cyc = 0; failures = 0; comparisons = 0; halts = 0; go = 1'b0;
    rst_in = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    t_frame();
    t_flush();
    t_skip();
    report_and_stop();
  end
endmodule
`default_nettype wire
